// File: bench/fhc_flash_model.sv
`timescale 1ns/1ps
module fhc_flash_model
	import fhc_pkg::*;
#(
	parameter int ALG_CYC = 30, // Embedded algorithm length in cycles
	parameter logic [3:0] SUSP_SECTOR = 4'h3 // Sector whose erase is suspended
)
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic elevated_i,
	input wire logic ce_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic word_byte_select_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o,
	output logic ready_busy_n_o,
	output logic standby_o,
	output logic [ADDR_W-1:0] wp_addr_o,
	output int viol_o
);
	// ************************************************************
	// Device state
	// ************************************************************
	logic [15:0] mem [16] = '{default: 16'h0000}; // Array, low address bits only
	logic [15:0] prog_data = 16'h0000; // Word being programmed
	logic [15:0] last_dq = 16'h0000; // Last level on the data lines
	logic tog6 = 1'b0; // Main toggle bit
	logic tog2 = 1'b0; // Suspend toggle bit
	logic rd_q = 1'b0; // Read frame one cycle ago
	logic we_q = 1'b1; // Write strobe one cycle ago
	logic elev_q = 1'b0; // Elevated level one cycle ago
	int busy_cnt = 0; // Cycles left in the algorithm
	int rst_low = 0; // Cycles of reset held low
	int rst_high = 1000; // Cycles since reset release
	int elev_cnt = 0; // Cycles at elevated level
	int rdy_cnt = 0; // Cycles since ready returned
	wire rd = !ce_n_i && !oe_n_i; // A read is framed by either enable
	wire rd_start = rd && !rd_q; // Enable high between reads splits them
	wire wr_end = we_n_i && !we_q && reset_n_i; // Write pulse ends
	wire early_rd = rd_start && rst_high < RH_CYC;
	wire early_wr = wr_end && elevated_i && elev_cnt < RSP_CYC;
	wire early_drop = elev_q && !elevated_i && rdy_cnt < RRB_CYC;

	assign ready_busy_n_o = (busy_cnt == 0); // Busy for the whole algorithm

	initial
	begin
		standby_o = 1'b0;
		viol_o = 0;
		wp_addr_o = '0;
	end

	// ************************************************************
	// Data lines
	// ************************************************************
	always_comb
	begin
		if (!rd)
			dq_o = ~last_dq; // Released lines keep no stale value
		else if (busy_cnt != 0)
			dq_o = {~last_dq[15:8], ~prog_data[7], tog6, 3'b000, tog2, 2'b00};
		else
			dq_o = mem[addr_i[3:0]]; // True data once done
		if (rd && !word_byte_select_i)
			dq_o[15:8] = ~last_dq[15:8]; // Upper lines float in byte mode, and in either mode during status reads while busy
	end

	// ************************************************************
	// Algorithm, reset and host timing watch
	// ************************************************************
	always @(posedge clock_i)
	begin
		rd_q <= rd;
		we_q <= we_n_i;
		elev_q <= elevated_i;
		last_dq <= dq_o;
		rdy_cnt <= ready_busy_n_o ? rdy_cnt + 1 : 0;
		elev_cnt <= elevated_i ? elev_cnt + 1 : 0;
		viol_o <= viol_o + int'(early_rd) + int'(early_wr) + int'(early_drop);
		if (busy_cnt != 0)
			busy_cnt <= busy_cnt - 1;
		if (!we_n_i)
			wp_addr_o <= addr_i;
		// Any write starts an algorithm
		if (wr_end)
		begin
			mem[addr_i[3:0]] <= dq_i;
			prog_data <= dq_i;
			busy_cnt <= ALG_CYC;
		end
		// Toggle on each new status read while busy
		if (rd_start && busy_cnt != 0)
		begin
			tog6 <= ~tog6; // Any address will do
			if (addr_i[19:16] == SUSP_SECTOR)
				tog2 <= ~tog2; // Only inside the suspended sector
		end
		if (!reset_n_i)
		begin
			rst_low <= rst_low + 1;
			rst_high <= 0;
			busy_cnt <= 0; // Abort at once, inside both limits
			standby_o <= (rst_low + 1 >= STBY_CYC);
		end
		else
		begin
			rst_low <= 0;
			rst_high <= rst_high + 1;
		end
	end
endmodule // fhc_flash_model

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench
	import fhc_pkg::*;
;
	// ************************************************************
	// Signals
	// ************************************************************
	localparam logic [3:0] SUSP = 4'h3; // Suspended sector
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [4:0] address_i = 5'h00;
	logic read_i = 1'b0;
	logic write_i = 1'b0;
	logic [31:0] writedata_i = 32'h0000_0000;
	logic rd_chk = 1'b0; // Current read is scored
	logic [31:0] readdata_o;
	logic waitrequest_o, irq_o, rst_n, elev, ce_n, oe_n, we_n, wbs, dq_oe, rbn;
	logic [ADDR_W-1:0] faddr;
	logic [15:0] dq_c, dq_m;
	wire [15:0] dq_bus = dq_oe ? dq_c : dq_m; // Shared data lines
	logic [31:0] exp_q [$]; // Expected read data
	logic [31:0] mask_q [$]; // Bits that count
	string name_q [$];
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;

	always #50 clock_i = ~clock_i;

	fhc_ctrl fhc_ctrl_i (.clock_i(clock_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
		.write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
		.irq_o(irq_o), .flash_reset_n_o(rst_n), .flash_elevated_o(elev), .flash_ce_n_o(ce_n),
		.flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .word_byte_select_o(wbs), .flash_addr_o(faddr),
		.flash_dq_i(dq_bus), .flash_dq_o(dq_c), .flash_dq_oe_o(dq_oe), .ready_busy_n_i(rbn));
	fhc_flash_model #(.SUSP_SECTOR(SUSP)) fhc_flash_model_i (.clock_i(clock_i), .reset_n_i(rst_n),
		.elevated_i(elev), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .word_byte_select_i(wbs),
		.addr_i(faddr), .dq_i(dq_bus), .dq_o(dq_m), .ready_busy_n_o(rbn), .standby_o(), .wp_addr_o(),
		.viol_o());

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	// One Avalon cycle, held until waitrequest is low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic c,
		output logic [31:0] q);
		read_i <= !wr;
		write_i <= wr;
		rd_chk <= c;
		address_i <= a;
		writedata_i <= d;
		@(posedge clock_i);
		while (waitrequest_o !== 1'b0)
			@(posedge clock_i);
		q = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 1'b0, q);
	endtask

	// Scored read: note the expectation, then run the cycle
	task automatic rd(input string n, input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] q;
		exp_q.push_back(e);
		mask_q.push_back(m);
		name_q.push_back(n);
		bus(1'b0, a, 32'h0000_0000, 1'b1, q);
	endtask

	// Command, then wait until the controller is idle
	task automatic op(input logic [3:0] code, input logic [1:0] flags);
		logic [31:0] q;
		wr(REG_CMD, {26'h0, flags, code});
		q = 32'h0000_0010;
		while (q[4] !== 1'b0)
			bus(1'b0, REG_STATUS, 32'h0000_0000, 1'b0, q);
	endtask

	// ************************************************************
	// Read monitor and timeout
	// ************************************************************
	always @(posedge clock_i)
	begin
		cyc++;
		if (read_i && !waitrequest_o && rd_chk)
		begin
			chk(name_q.pop_front(), exp_q[0] & mask_q[0], readdata_o & mask_q[0]);
			exp_q.delete(0);
			mask_q.delete(0);
		end
		// Ceiling on the run: a hang counts as a mismatch
		if (cyc == 20000)
		begin
			miscompares++;
			complete_run();
		end
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		logic [15:0] d;
		logic [19:0] a;
		void'($urandom(63));
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		// Reset values and an unmapped place
		rd("status", REG_STATUS, 32'h0000_0020, 32'h0000_00FF);
		rd("irq_stat", REG_IRQ_STAT, 32'h0, 32'hFFFF_FFFF);
		rd("irq_en", REG_IRQ_EN, 32'h0, 32'hFFFF_FFFF);
		rd("rdata", REG_RDATA, RESET_WORD, 32'hFFFF_FFFF);
		rd("unmapped", 5'h1E, 32'h0, 32'hFFFF_FFFF);
		wr(REG_IRQ_EN, 32'h0000_0007);
		// Program then poll, outside and inside the suspended sector, OE then CE framing
		for (int k = 0; k < 2; k++)
		begin
			a = {(k == 0) ? 4'h1 : SUSP, 12'h000, 4'(k)};
			// Outside the suspended sector bit 2 must not flip when true data replaces status
			d = 16'($urandom) & ((k == 0) ? 16'hFFFB : 16'hFFFF);
			wr(REG_ADDR, {12'h0, a});
			wr(REG_WDATA, {16'h0, d});
			op(OP_WRITE, 2'b00);
			op(OP_POLL, 2'(k * 2));
			rd("status", REG_STATUS, {26'h0, 1'b1, 2'b00, d[7], d[6], 1'b0}, 32'h36);
			rd("irq_stat", REG_IRQ_STAT, {29'h0, 1'(k), 2'b01}, 32'h5);
			chk("irq", 32'h1, {31'h0, irq_o});
			wr(REG_IRQ_CLR, 32'h0000_0007);
			chk("irq", 32'h0, {31'h0, irq_o});
			op(OP_READ, 2'b00);
			rd("rdata", REG_RDATA, {16'h0, d}, 32'hFFFF_FFFF);
		end
		// Reset during an algorithm, for standby, and while idle
		for (int j = 0; j < 3; j++)
		begin
			if (j == 0)
				op(OP_WRITE, 2'b00);
			op(OP_RESET, {1'b0, 1'(j == 1)});
			chk("standby", {31'h0, 1'(j != 2)}, {31'h0, fhc_flash_model_i.standby_o});
			rd("status", REG_STATUS, 32'h20, 32'h30);
		end
		op(OP_READ, 2'b00);
		rd("rdata", REG_RDATA, {16'h0, d}, 32'hFFFF_FFFF);
		// Protect and unprotect address patterns
		for (int p = 0; p < 2; p++)
		begin
			a = 20'($urandom);
			wr(REG_ADDR, {12'h0, a});
			op((p == 0) ? OP_PROTECT : OP_UNPROTECT, 2'b00);
			chk("prot_addr", {12'h0, (a & ~20'h00043) | ((p == 0) ? 20'h00002 : 20'h00042)},
				{12'h0, fhc_flash_model_i.wp_addr_o});
		end
		// Temporary unprotect with a program inside it
		op(OP_TU_ENTER, 2'b00);
		rd("tu_mode", REG_STATUS, 32'h80, 32'h80);
		d = 16'($urandom);
		wr(REG_ADDR, 32'h0001_0000);
		wr(REG_WDATA, {16'h0, d});
		op(OP_WRITE, 2'b00);
		op(OP_POLL, 2'b00);
		op(OP_TU_EXIT, 2'b00);
		rd("tu_mode", REG_STATUS, 32'h20, 32'hA0);
		chk("elevated", 32'h0, {31'h0, elev});
		// Width switch, with the interrupt masked
		wr(REG_IRQ_EN, 32'h0);
		for (int w = 0; w < 2; w++)
		begin
			wr(REG_WDATA, 32'(w));
			op(OP_WIDTH, 2'b00);
			rd("byte_mode", REG_STATUS, {25'h0, 1'(w == 0), 6'h00}, 32'h40);
			op(OP_READ, 2'b00);
			rd("rdata", REG_RDATA, {16'h0, (w == 1) ? d : {8'h00, d[7:0]}}, 32'hFFFF_FFFF);
			chk("irq_masked", 32'h0, {31'h0, irq_o});
		end
		rd("irq_stat", REG_IRQ_STAT, 32'h1, 32'h1);
		chk("host_timing", 32'h0, 32'(fhc_flash_model_i.viol_o));
		chk("pending", 32'h0, 32'(exp_q.size()));
		complete_run();
	end
endmodule // testbench

// File: rtl/fhc_ctrl.sv
// Summary of operation
// - Wait 50ns after reset release before reading.
// - Hold reset 20us low to reach standby.
// - Status reads framed by output or chip enable.
// - Main toggle polling accepts any address.
// - Protect drives A6 low, A1 high, A0 low.
// - Unprotect drives A6 high, A1 high, A0 low.
// - Elevated reset held 4us before first write.
// - Elevated reset held 4us after ready returns.
// - Output enable high between status reads; with chip enable framing, chip enable goes high instead.
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module fhc_ctrl
	import fhc_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [4:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	output logic irq_o,
	output logic flash_reset_n_o,
	output logic flash_elevated_o,
	output logic flash_ce_n_o,
	output logic flash_oe_n_o,
	output logic flash_we_n_o,
	output logic word_byte_select_o,
	output logic [ADDR_W-1:0] flash_addr_o,
	input wire logic [15:0] flash_dq_i,
	output logic [15:0] flash_dq_o,
	output logic flash_dq_oe_o,
	input wire logic ready_busy_n_i
);

	// ************************************************************
	// Declarations
	// ************************************************************
	fhc_state_e state_ff, nxt_state; // Sequencer state
	logic [ADDR_W-1:0] addr_ff; // Flash address register
	logic [15:0] wdata_ff; // Write data register
	logic [15:0] rdata_ff; // Last data read
	logic [IRQ_W-1:0] irq_stat_ff, irq_en_ff, nxt_irq_stat;
	logic stby_ff, ce_frame_ff; // Operation options
	logic prot_ff, unprot_ff; // Protect sequence running
	logic tu_mode_ff; // Temporary unprotect active
	logic wbs_ff; // Word (1) or byte (0) mode
	logic poll_first_ff; // First status read of a poll
	logic dq6_ff, dq2_ff, dq7_ff; // Last status bits
	logic susp_seen_ff; // Suspend toggle seen in this poll
	logic rb_ff; // Previous ready/busy
	logic rd_ack_ff; // Read answered
	logic [31:0] readdata_ff;
	logic tmr_load, tmr_done;
	logic [TMR_W-1:0] tmr_val;

	// ************************************************************
	// Bus decode
	// ************************************************************
	wire sel_cmd = (address_i == REG_CMD);
	wire sel_addr = (address_i == REG_ADDR);
	wire sel_wdata = (address_i == REG_WDATA);
	wire sel_clr = (address_i == REG_IRQ_CLR);
	wire sel_en = (address_i == REG_IRQ_EN);
	wire idle = (state_ff == S_IDLE);
	wire cmd_go = write_i & sel_cmd & idle; // Command taken only when idle
	wire [3:0] op = writedata_i[3:0];
	wire cap_rd = (state_ff == S_RD) & tmr_done; // Read data sampled
	wire cap_poll = (state_ff == S_POLL_RD) & tmr_done; // Status sampled
	wire main_tog = flash_dq_i[6] ^ dq6_ff; // Main toggle bit changed
	wire poll_end = cap_poll & ~poll_first_ff & ~main_tog; // Toggling stopped
	wire [31:0] status_word = {24'h0, tu_mode_ff, ~wbs_ff, ready_busy_n_i, ~idle,
		susp_seen_ff, dq7_ff, dq6_ff, prot_ff};
	wire [31:0] rd_mux;
	wire [IRQ_W-1:0] events;

	// Read data selection
	assign rd_mux = (address_i == REG_ADDR) ? {12'h0, addr_ff} :
		(address_i == REG_WDATA) ? {16'h0, wdata_ff} :
		(address_i == REG_RDATA) ? {16'h0, rdata_ff} :
		(address_i == REG_STATUS) ? status_word :
		(address_i == REG_IRQ_STAT) ? {29'h0, irq_stat_ff} :
		(address_i == REG_IRQ_EN) ? {29'h0, irq_en_ff} : 32'h0;

	// Reads wait one cycle, commands wait while busy
	assign waitrequest_o = (read_i & ~rd_ack_ff) | (write_i & sel_cmd & ~idle);
	assign readdata_o = readdata_ff;

	// ************************************************************
	// Events and interrupt
	// ************************************************************
	assign events = {cap_poll & ~poll_first_ff & (flash_dq_i[2] ^ dq2_ff),
		ready_busy_n_i & ~rb_ff, ~idle & (nxt_state == S_IDLE)};
	// Set wins over clear
	assign nxt_irq_stat = (irq_stat_ff & ~((write_i & sel_clr) ? writedata_i[IRQ_W-1:0] : '0)) | events;
	assign irq_o = |(irq_stat_ff & irq_en_ff);

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_comb
	begin
		nxt_state = state_ff;
		tmr_load = 1'b0;
		tmr_val = '0;
		case (state_ff)
			S_IDLE:
				if (cmd_go)
				begin
					tmr_load = 1'b1;
					if (op == OP_READ)
					begin
						nxt_state = S_RD;
						tmr_val = TMR_W'(ACC_CYC - 1);
					end
					else if (op == OP_WRITE)
					begin
						nxt_state = S_WR;
						tmr_val = TMR_W'(WP_CYC - 1);
					end
					else if (op == OP_RESET)
					begin
						nxt_state = S_RST_LOW;
						// Hold until the device is surely back in read mode, or in standby
						if (writedata_i[CMD_STBY_BIT])
							tmr_val = TMR_W'(STBY_CYC - 1);
						else if (!ready_busy_n_i)
							tmr_val = TMR_W'(READY_ALG_CYC - 1);
						else
							tmr_val = TMR_W'(((READY_IDLE_CYC > RP_CYC) ? READY_IDLE_CYC : RP_CYC) - 1);
					end
					else if (op == OP_POLL)
					begin
						nxt_state = S_POLL_RD;
						tmr_val = TMR_W'(ACC_CYC - 1);
					end
					else if (op == OP_PROTECT || op == OP_UNPROTECT)
					begin
						nxt_state = S_PROT_SET;
						tmr_val = TMR_W'(RSP_CYC - 1);
					end
					else if (op == OP_TU_ENTER)
					begin
						nxt_state = S_TU_SETUP;
						tmr_val = TMR_W'(RSP_CYC - 1);
					end
					else if (op == OP_TU_EXIT)
						nxt_state = S_RB_WAIT;
					else if (op == OP_WIDTH)
					begin
						nxt_state = S_WIDTH;
						tmr_val = TMR_W'(FHQV_CYC - 1);
					end
				end
			S_RD, S_TU_SETUP, S_WIDTH, S_ELEV_HOLD:
				if (tmr_done)
					nxt_state = S_IDLE;
			S_WR:
				if (tmr_done)
					nxt_state = S_WR_REC;
			S_WR_REC:
				nxt_state = prot_ff ? S_RB_WAIT : S_IDLE;
			S_RST_LOW:
				if (tmr_done)
				begin
					nxt_state = S_RST_REC;
					tmr_load = 1'b1;
					tmr_val = TMR_W'(RH_CYC - 1);
				end
			S_RST_REC:
				if (tmr_done)
					nxt_state = S_IDLE;
			S_POLL_RD:
				if (poll_end)
					nxt_state = S_IDLE;
				else if (tmr_done)
				begin
					nxt_state = S_POLL_GAP;
					tmr_load = 1'b1;
					tmr_val = TMR_W'(OEPH_CYC - 1);
				end
			S_POLL_GAP:
				if (tmr_done)
				begin
					nxt_state = S_POLL_RD;
					tmr_load = 1'b1;
					tmr_val = TMR_W'(ACC_CYC - 1);
				end
			S_PROT_SET:
				if (tmr_done)
				begin
					nxt_state = S_WR;
					tmr_load = 1'b1;
					tmr_val = TMR_W'(WP_CYC - 1);
				end
			S_RB_WAIT:
				// Wait for ready, then keep the elevated level on
				if (ready_busy_n_i)
				begin
					nxt_state = S_ELEV_HOLD;
					tmr_load = 1'b1;
					tmr_val = TMR_W'(RRB_CYC - 1);
				end
			default:
				nxt_state = S_IDLE;
		endcase
	end

	// Wait timer
	fhc_timer u_timer (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.load_i(tmr_load),
		.load_val_i(tmr_val),
		.done_o(tmr_done)
	);

	// ************************************************************
	// Flash pins
	// ************************************************************
	wire rd_phase = (state_ff == S_RD) | (state_ff == S_POLL_RD);
	wire gap = (state_ff == S_POLL_GAP);
	assign flash_reset_n_o = (state_ff != S_RST_LOW);
	assign flash_elevated_o = tu_mode_ff | prot_ff;
	assign flash_ce_n_o = ~(rd_phase | (state_ff == S_WR) | (gap & ~ce_frame_ff));
	assign flash_oe_n_o = ~(rd_phase | (gap & ce_frame_ff));
	assign flash_we_n_o = (state_ff != S_WR);
	assign flash_dq_oe_o = (state_ff == S_WR) | (state_ff == S_WR_REC);
	assign flash_dq_o = wdata_ff;
	assign word_byte_select_o = wbs_ff;
	// Protect address pattern overrides A6, A1, A0; polling uses any address
	assign flash_addr_o = prot_ff ? {addr_ff[ADDR_W-1:7], unprot_ff, addr_ff[5:2], 2'b10} : addr_ff;

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			state_ff <= S_IDLE;
			addr_ff <= '0;
			wdata_ff <= RESET_WORD[15:0];
			rdata_ff <= RESET_WORD[15:0];
			irq_stat_ff <= '0;
			irq_en_ff <= '0;
			rd_ack_ff <= 1'b0;
			readdata_ff <= RESET_WORD;
			rb_ff <= 1'b1;
		end
		else
		begin
			state_ff <= nxt_state;
			irq_stat_ff <= nxt_irq_stat;
			rd_ack_ff <= read_i & ~rd_ack_ff;
			rb_ff <= ready_busy_n_i;
			if (read_i & ~rd_ack_ff)
				readdata_ff <= rd_mux;
			if (write_i & sel_addr)
				addr_ff <= writedata_i[ADDR_W-1:0];
			if (write_i & sel_wdata)
				wdata_ff <= writedata_i[15:0];
			if (write_i & sel_en)
				irq_en_ff <= writedata_i[IRQ_W-1:0];
			// Byte mode keeps only the low lane
			if (cap_rd)
				rdata_ff <= wbs_ff ? flash_dq_i : {8'h0, flash_dq_i[7:0]};
		end
	end

	// Operation options and modes
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			stby_ff <= 1'b0;
			ce_frame_ff <= 1'b0;
			prot_ff <= 1'b0;
			unprot_ff <= 1'b0;
			tu_mode_ff <= 1'b0;
			wbs_ff <= 1'b1;
		end
		else
		begin
			if (cmd_go)
			begin
				stby_ff <= writedata_i[CMD_STBY_BIT];
				ce_frame_ff <= writedata_i[CMD_CEFRAME_BIT];
				unprot_ff <= (op == OP_UNPROTECT);
			end
			if (cmd_go & (op == OP_PROTECT || op == OP_UNPROTECT))
				prot_ff <= 1'b1;
			if (cmd_go & (op == OP_TU_ENTER))
				tu_mode_ff <= 1'b1;
			// Width comes from the write data register, since bit 0 of the command word is part of the opcode
			if (cmd_go & (op == OP_WIDTH))
				wbs_ff <= wdata_ff[0];
			if ((state_ff == S_ELEV_HOLD) & tmr_done)
			begin
				prot_ff <= 1'b0;
				tu_mode_ff <= 1'b0;
			end
		end
	end

	// Status sampling during polls
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			poll_first_ff <= 1'b0;
			dq6_ff <= 1'b0;
			dq2_ff <= 1'b0;
			dq7_ff <= 1'b0;
			susp_seen_ff <= 1'b0;
		end
		else if (cmd_go & (op == OP_POLL))
		begin
			poll_first_ff <= 1'b1;
			susp_seen_ff <= 1'b0;
		end
		else if (cap_poll)
		begin
			poll_first_ff <= 1'b0;
			dq6_ff <= flash_dq_i[6];
			dq2_ff <= flash_dq_i[2];
			dq7_ff <= flash_dq_i[7];
			if (!poll_first_ff && (flash_dq_i[2] ^ dq2_ff))
				susp_seen_ff <= 1'b1;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	logic [2:0] rel_cnt_ff; // Cycles since reset release
	logic [8:0] low_cnt_ff; // Cycles reset held low
	logic [5:0] elev_cnt_ff; // Cycles elevated level held
	logic [5:0] rbh_cnt_ff; // Cycles ready/busy high
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			rel_cnt_ff <= 3'h7;
			low_cnt_ff <= 9'h000;
			elev_cnt_ff <= 6'h00;
			rbh_cnt_ff <= 6'h00;
		end
		else
		begin
			rel_cnt_ff <= !flash_reset_n_o ? 3'h0 : (rel_cnt_ff == 3'h7 ? rel_cnt_ff : rel_cnt_ff + 3'h1);
			low_cnt_ff <= flash_reset_n_o ? 9'h000 : (&low_cnt_ff ? low_cnt_ff : low_cnt_ff + 9'h001);
			elev_cnt_ff <= !flash_elevated_o ? 6'h00 : (&elev_cnt_ff ? elev_cnt_ff : elev_cnt_ff + 6'h01);
			rbh_cnt_ff <= !ready_busy_n_i ? 6'h00 : (&rbh_cnt_ff ? rbh_cnt_ff : rbh_cnt_ff + 6'h01);
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	AST_READ_AFTER_RELEASE: assert property ($fell(flash_oe_n_o) |-> rel_cnt_ff >= RH_CYC)
		else $error("Read started too soon after reset release");
	AST_STANDBY_HOLD: assert property ($rose(flash_reset_n_o) && stby_ff |-> low_cnt_ff >= STBY_CYC)
		else $error("Standby reset released too early");
	AST_PROTECT_ADDR: assert property (!flash_we_n_o && prot_ff && !unprot_ff
		|-> flash_addr_o[6] == 1'b0 && flash_addr_o[1:0] == 2'b10)
		else $error("Protect address pattern wrong");
	AST_UNPROTECT_ADDR: assert property (!flash_we_n_o && prot_ff && unprot_ff
		|-> flash_addr_o[6] == 1'b1 && flash_addr_o[1:0] == 2'b10)
		else $error("Unprotect address pattern wrong");
	AST_ELEV_SETUP: assert property (!flash_we_n_o && flash_elevated_o |-> elev_cnt_ff >= RSP_CYC)
		else $error("Write issued before elevated setup time");
	AST_ELEV_HOLD: assert property ($fell(flash_elevated_o) |-> rbh_cnt_ff >= RRB_CYC)
		else $error("Elevated level dropped too soon after ready");
	AST_POLL_OE_GAP: assert property (cap_poll && !poll_end && !ce_frame_ff
		|=> flash_oe_n_o && !flash_ce_n_o ##1 !flash_oe_n_o)
		else $error("No output enable gap between status reads");
	AST_POLL_CE_FRAME: assert property (cap_poll && !poll_end && ce_frame_ff
		|=> flash_ce_n_o && !flash_oe_n_o ##1 !flash_ce_n_o)
		else $error("No chip enable gap between status reads");
	AST_POLL_ADDR: assert property (state_ff == S_POLL_RD |-> flash_addr_o == addr_ff && flash_reset_n_o)
		else $error("Poll read address not held");
	AST_READ_WAIT: assert property (read_i && !waitrequest_o |-> $past(read_i) && $past(waitrequest_o))
		else $error("Read answered without one wait cycle");

	COV_POLL_DONE: cover property (cap_poll && poll_end);
	COV_STANDBY: cover property ($rose(flash_reset_n_o) && stby_ff);
	COV_PROTECT: cover property ($fell(flash_elevated_o) && !tu_mode_ff);

endmodule // fhc_ctrl

// File: rtl/fhc_pkg.sv
package fhc_pkg;

	// ************************************************************
	// Clock and pin timing
	// ************************************************************
	localparam int CLK_NS = 100; // System clock period
	localparam int TMR_W = 9; // Width of the wait timer
	localparam int T_READY_ALG_NS = 20000; // Reset low to read mode, algorithm running
	localparam int T_READY_IDLE_NS = 500; // Reset low to read mode, no algorithm
	localparam int T_RP_NS = 500; // Least reset pulse width
	localparam int T_RH_NS = 50; // Reset high before first read
	localparam int T_STBY_NS = 20000; // Reset low to standby
	localparam int T_FHQV_NS = 85; // Width switch to outputs settled (slow grade)
	localparam int T_RSP_NS = 4000; // Elevated reset setup before first write
	localparam int T_RRB_NS = 4000; // Elevated reset hold after ready
	localparam int T_OEPH_NS = 20; // Enable high between status reads
	localparam int T_ACC_NS = 85; // Access time (slow grade)
	localparam int T_WP_NS = 35; // Write pulse width (slow grade)
	// Least times round up to whole cycles
	localparam int READY_ALG_CYC = (T_READY_ALG_NS + CLK_NS - 1) / CLK_NS;
	localparam int READY_IDLE_CYC = (T_READY_IDLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RH_CYC = (T_RH_NS + CLK_NS - 1) / CLK_NS;
	localparam int STBY_CYC = (T_STBY_NS + CLK_NS - 1) / CLK_NS;
	localparam int FHQV_CYC = (T_FHQV_NS + CLK_NS - 1) / CLK_NS;
	localparam int RSP_CYC = (T_RSP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RRB_CYC = (T_RRB_NS + CLK_NS - 1) / CLK_NS;
	localparam int OEPH_CYC = (T_OEPH_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;

	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [4:0] REG_CMD = 5'h00; // Command, write starts an operation
	localparam logic [4:0] REG_ADDR = 5'h04; // Flash address
	localparam logic [4:0] REG_WDATA = 5'h08; // Write data
	localparam logic [4:0] REG_RDATA = 5'h0C; // Read data
	localparam logic [4:0] REG_STATUS = 5'h10; // Live status
	localparam logic [4:0] REG_IRQ_STAT = 5'h14; // Sticky events
	localparam logic [4:0] REG_IRQ_CLR = 5'h18; // Write one to clear
	localparam logic [4:0] REG_IRQ_EN = 5'h1C; // Event enables
	localparam int CMD_STBY_BIT = 4; // Reset op: hold for standby
	localparam int CMD_CEFRAME_BIT = 5; // Poll op: frame reads with chip enable
	localparam int IRQ_W = 3; // Event count
	localparam int ADDR_W = 20; // Flash word address width
	localparam logic [31:0] RESET_WORD = 32'h0000_0000; // Value of data registers after reset

	// ************************************************************
	// Opcodes and states
	// ************************************************************
	localparam logic [3:0] OP_READ = 4'h1;
	localparam logic [3:0] OP_WRITE = 4'h2;
	localparam logic [3:0] OP_RESET = 4'h3;
	localparam logic [3:0] OP_POLL = 4'h4;
	localparam logic [3:0] OP_PROTECT = 4'h5;
	localparam logic [3:0] OP_UNPROTECT = 4'h6;
	localparam logic [3:0] OP_TU_ENTER = 4'h7;
	localparam logic [3:0] OP_TU_EXIT = 4'h8;
	localparam logic [3:0] OP_WIDTH = 4'h9;

	typedef enum logic [3:0] {
		S_IDLE, S_RD, S_WR, S_WR_REC, S_RST_LOW, S_RST_REC, S_POLL_RD, S_POLL_GAP,
		S_PROT_SET, S_RB_WAIT, S_ELEV_HOLD, S_TU_SETUP, S_WIDTH
	} fhc_state_e;

endpackage

// File: rtl/fhc_timer.sv
`timescale 1ns/1ps
module fhc_timer
	import fhc_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [TMR_W-1:0] load_val_i,
	output logic done_o
);

	logic [TMR_W-1:0] count_ff; // Remaining cycles
	logic [TMR_W-1:0] nxt_count;

	// Load wins, otherwise count down to zero and stay
	assign nxt_count = load_i ? load_val_i : (count_ff != '0 ? count_ff - 1'b1 : count_ff);
	assign done_o = (count_ff == '0);

	// Down counter
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			count_ff <= '0;
		else
			count_ff <= nxt_count;
	end

endmodule // fhc_timer
